// >>> hw/multimode_timer.sv
// The implementer's own choices: the register offsets and the strobed register port.

`timescale 1ns/1ps
`include "timer_consts.svh"

module multimode_timer (
    input  wire logic                      clock,
    input  wire logic                      rst_b,
    input  wire logic [7:0]                addr,
    input  wire logic [15:0]               wdata,
    input  wire logic                      wr_en,
    input  wire logic                      rd_en,
    output logic      [15:0]               rdata,
    input  wire logic [`TMR_NUM_A-1:0]     group_a_trigger_input_pin,
    output logic      [`TMR_NUM_A-1:0]     group_a_pulse_output_pin,
    input  wire logic [`TMR_NUM_B-1:0]     group_b_event_input_pin,
    output logic      [`TMR_NUM_ALL-1:0]   irq_request
);

    // ------------------------------------------------------------------------
    // Count source prescaler
    // ------------------------------------------------------------------------
    logic [11:0] div_cnt_q;
    logic [11:0] div_cnt_d;
    logic [5:0]  ticks;
    logic        main_oscillator_div32_clock;

    always_comb begin
        div_cnt_d = div_cnt_q + 12'h001;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            div_cnt_q <= 12'h000;
        end else begin
            div_cnt_q <= div_cnt_d;
        end
    end

    // Ticks in order f1, f2, f16, f64, f512, f4096 of the system clock.
    assign ticks[0] = 1'b1;
    assign ticks[1] = div_cnt_q[0];
    assign ticks[2] = &div_cnt_q[3:0];
    assign ticks[3] = &div_cnt_q[5:0];
    assign ticks[4] = &div_cnt_q[8:0];
    assign ticks[5] = &div_cnt_q[11:0];
    // The oscillator is taken to be the system clock itself.
    assign main_oscillator_div32_clock = (div_cnt_q & `TMR_MAIN_OSCILLATOR_DIV32_CLOCK_MASK) == `TMR_MAIN_OSCILLATOR_DIV32_CLOCK_MASK;

    // A forbidden division setting stops the count rather than guessing a rate.
    function automatic logic pick_tick(input logic [1:0] div, input logic [1:0] sel, input logic [5:0] t);
        logic r;
        r = 1'b0;
        if (div != `TMR_DIV_FORBIDDEN) begin
            case (sel)
                2'h0: r = (div == 2'h0) ? t[1] : t[0];
                2'h1: r = (div == 2'h2) ? t[3] : t[2];
                2'h2: r = (div == 2'h2) ? t[4] : t[3];
                default: r = (div == 2'h0) ? t[4] : t[5];
            endcase
        end
        return r;
    endfunction

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [`TMR_NUM_A-1:0] trg_s1_q;
    logic [`TMR_NUM_A-1:0] trg_s2_q;
    logic [`TMR_NUM_A-1:0] trg_old_q;
    logic [`TMR_NUM_B-1:0] evt_s1_q;
    logic [`TMR_NUM_B-1:0] evt_s2_q;
    logic [`TMR_NUM_B-1:0] evt_old_q;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            trg_s1_q  <= '0;
            trg_s2_q  <= '0;
            trg_old_q <= '0;
            evt_s1_q  <= '0;
            evt_s2_q  <= '0;
            evt_old_q <= '0;
        end else begin
            trg_s1_q  <= group_a_trigger_input_pin;
            trg_s2_q  <= trg_s1_q;
            trg_old_q <= trg_s2_q;
            evt_s1_q  <= group_b_event_input_pin;
            evt_s2_q  <= evt_s1_q;
            evt_old_q <= evt_s2_q;
        end
    end

    // ------------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------------
    logic [`TMR_NUM_ALL-1:0] cs_q;
    logic [`TMR_NUM_ALL-1:0] cs_d;
    logic [1:0]              div_q;
    logic [1:0]              div_d;
    logic                    main_oscillator_div32_clock_q;
    logic                    main_oscillator_div32_clock_d;
    logic [`TMR_NUM_ALL-1:0] flags_q;
    logic [`TMR_NUM_ALL-1:0] flags_d;
    logic [15:0]             rdata_q;
    logic [15:0]             rdata_d;
    logic [7:0]              mode_a_q [`TMR_NUM_A];
    logic [7:0]              mode_a_d [`TMR_NUM_A];
    logic [7:0]              mode_b_q [`TMR_NUM_B];
    logic [7:0]              mode_b_d [`TMR_NUM_B];
    logic [`TMR_NUM_ALL-1:0] set_vec;
    timer_pkg::timer_a_state_t a_q [`TMR_NUM_A];
    timer_pkg::timer_a_state_t a_d [`TMR_NUM_A];
    timer_pkg::timer_b_state_t b_q [`TMR_NUM_B];
    timer_pkg::timer_b_state_t b_d [`TMR_NUM_B];

    always_comb begin
        cs_d     = cs_q;
        div_d    = div_q;
        main_oscillator_div32_clock_d   = main_oscillator_div32_clock_q;
        flags_d  = flags_q;
        rdata_d  = 16'h0000;
        mode_a_d = mode_a_q;
        mode_b_d = mode_b_q;
        if (wr_en) begin
            case (addr)
                `TMR_ADDR_COUNT_START: cs_d = wdata[`TMR_NUM_ALL-1:0];
                `TMR_ADDR_CLK_DIV:     div_d = wdata[1:0];
                `TMR_ADDR_MAIN_OSCILLATOR_DIV32_CLOCK_SEL:    main_oscillator_div32_clock_d = wdata[0];
                `TMR_ADDR_IRQ_FLAGS:   flags_d = flags_q & ~wdata[`TMR_NUM_ALL-1:0];
                default: ;
            endcase
            for (int i = 0; i < `TMR_NUM_A; i++) begin
                if (addr == 8'(`TMR_ADDR_A_BASE + 2 * i)) begin
                    mode_a_d[i] = wdata[7:0];
                end
            end
            for (int j = 0; j < `TMR_NUM_B; j++) begin
                if (addr == 8'(`TMR_ADDR_B_BASE + 2 * j)) begin
                    mode_b_d[j] = wdata[7:0];
                end
            end
        end
        // A hardware event in the clearing cycle is kept.
        flags_d = flags_d | set_vec;
        if (rd_en) begin
            case (addr)
                `TMR_ADDR_COUNT_START: rdata_d = {11'h000, cs_q};
                `TMR_ADDR_CLK_DIV:     rdata_d = {14'h0000, div_q};
                `TMR_ADDR_MAIN_OSCILLATOR_DIV32_CLOCK_SEL:    rdata_d = {15'h0000, main_oscillator_div32_clock_q};
                `TMR_ADDR_IRQ_FLAGS:   rdata_d = {11'h000, flags_q};
                default: ;
            endcase
            for (int i = 0; i < `TMR_NUM_A; i++) begin
                if (addr == 8'(`TMR_ADDR_A_BASE + 2 * i)) begin
                    rdata_d = {8'h00, mode_a_q[i]};
                end
                if (addr == 8'(`TMR_ADDR_A_BASE + 2 * i + 1)) begin
                    rdata_d = a_q[i].rel;
                end
            end
            for (int j = 0; j < `TMR_NUM_B; j++) begin
                if (addr == 8'(`TMR_ADDR_B_BASE + 2 * j)) begin
                    rdata_d = {8'h00, mode_b_q[j]};
                end
                if (addr == 8'(`TMR_ADDR_B_BASE + 2 * j + 1)) begin
                    rdata_d = b_q[j].cnt;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cs_q    <= '0;
            div_q   <= `TMR_DIV_RESET;
            main_oscillator_div32_clock_q  <= 1'b0;
            flags_q <= '0;
            rdata_q <= 16'h0000;
            for (int i = 0; i < `TMR_NUM_A; i++) begin
                mode_a_q[i] <= `TMR_MODE_RESET;
            end
            for (int j = 0; j < `TMR_NUM_B; j++) begin
                mode_b_q[j] <= `TMR_MODE_RESET;
            end
        end else begin
            cs_q     <= cs_d;
            div_q    <= div_d;
            main_oscillator_div32_clock_q   <= main_oscillator_div32_clock_d;
            flags_q  <= flags_d;
            rdata_q  <= rdata_d;
            mode_a_q <= mode_a_d;
            mode_b_q <= mode_b_d;
        end
    end

    assign rdata       = rdata_q;
    assign irq_request = flags_q;

    // ------------------------------------------------------------------------
    // Group A timers
    // ------------------------------------------------------------------------
    generate
        for (genvar i = 0; i < `TMR_NUM_A; i++) begin : g_a
            timer_pkg::a_kind_t kind;
            logic               tick;
            logic               ext_edge;
            logic               sw_trig;
            logic               wr_hit;
            logic               step;
            logic [15:0]        last;
            logic [15:0]        width;
            logic [15:0]        per_inc;

            always_comb begin
                kind     = timer_pkg::A_IDLE;
                set_vec[i] = 1'b0;
                a_d[i]   = a_q[i];
                tick     = pick_tick(div_q, mode_a_q[i][7:6], ticks);
                ext_edge = mode_a_q[i][`TMR_A_EDGE_BIT] ? (trg_s2_q[i] & ~trg_old_q[i])
                                                        : (~trg_s2_q[i] & trg_old_q[i]);
                sw_trig  = wr_en && addr == `TMR_ADDR_ONESHOT_TRG && wdata[i];
                wr_hit   = wr_en && addr == 8'(`TMR_ADDR_A_BASE + 2 * i + 1);
                last     = mode_a_q[i][`TMR_A_PWM8_BIT] ? `TMR_PWM8_LAST : `TMR_PWM16_LAST;
                width    = mode_a_q[i][`TMR_A_PWM8_BIT] ? {8'h00, a_q[i].rel[15:8]} : a_q[i].rel;
                per_inc  = a_q[i].per + 16'h0001;
                step     = tick;
                if (mode_a_q[i][2:0] == `TMR_A_ONESHOT_CODE && !mode_a_q[i][`TMR_A_PWM8_BIT]) begin
                    kind = timer_pkg::A_ONESHOT;
                end else if (mode_a_q[i][2:0] == `TMR_A_PWM_CODE) begin
                    kind = timer_pkg::A_PWM;
                end
                case (kind)
                    timer_pkg::A_ONESHOT: begin
                        if (!cs_q[i]) begin
                            a_d[i].run = 1'b0;
                            a_d[i].out = 1'b0;
                        end else if (mode_a_q[i][`TMR_A_EXT_BIT] ? ext_edge : sw_trig) begin
                            if (a_q[i].run) begin
                                a_d[i].cnt = a_q[i].rel;
                            end else if (a_q[i].cnt != 16'h0000) begin
                                a_d[i].run = 1'b1;
                                a_d[i].out = 1'b1;
                            end
                        end else if (a_q[i].run && tick) begin
                            if (a_q[i].cnt == 16'h0001) begin
                                a_d[i].run = 1'b0;
                                a_d[i].out = 1'b0;
                                a_d[i].cnt = a_q[i].rel;
                                set_vec[i] = 1'b1;
                            end else begin
                                a_d[i].cnt = a_q[i].cnt - 16'h0001;
                            end
                        end
                    end
                    timer_pkg::A_PWM: begin
                        if (mode_a_q[i][`TMR_A_PWM8_BIT] && tick) begin
                            // Low byte prescaler ticks the modulator every n+1 source cycles.
                            step = a_q[i].pre == 8'h00;
                            a_d[i].pre = step ? a_q[i].rel[7:0] : a_q[i].pre - 8'h01;
                        end else if (mode_a_q[i][`TMR_A_PWM8_BIT]) begin
                            step = 1'b0;
                        end
                        if (!cs_q[i]) begin
                            a_d[i].run = 1'b0;
                            a_d[i].out = 1'b0;
                        end else if (!a_q[i].run) begin
                            if (!mode_a_q[i][`TMR_A_EXT_BIT] || ext_edge) begin
                                a_d[i].run = 1'b1;
                                a_d[i].per = 16'h0000;
                                a_d[i].pre = a_q[i].rel[7:0];
                                a_d[i].cnt = width;
                                a_d[i].out = width != 16'h0000;
                            end
                        end else if (step) begin
                            if (a_q[i].per == last) begin
                                a_d[i].per = 16'h0000;
                                a_d[i].cnt = width;
                                a_d[i].out = width != 16'h0000;
                            end else begin
                                a_d[i].per = per_inc;
                                a_d[i].out = per_inc < a_q[i].cnt;
                            end
                            set_vec[i] = a_q[i].out && !a_d[i].out;
                        end
                    end
                    default: begin
                        a_d[i].run = 1'b0;
                        a_d[i].out = 1'b0;
                    end
                endcase
                if (wr_hit) begin
                    a_d[i].rel = wdata;
                    if (!a_q[i].run) begin
                        a_d[i].cnt = wdata;
                    end
                end
            end

            always_ff @(posedge clock) begin
                if (!rst_b) begin
                    a_q[i] <= '0;
                end else begin
                    a_q[i] <= a_d[i];
                end
            end

            assign group_a_pulse_output_pin[i] = a_q[i].out;
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Group B timers
    // ------------------------------------------------------------------------
    generate
        for (genvar j = 0; j < `TMR_NUM_B; j++) begin : g_b
            logic evt;
            logic count;
            logic wr_hit;

            always_comb begin
                b_d[j] = b_q[j];
                set_vec[`TMR_NUM_A + j] = 1'b0;
                wr_hit = wr_en && addr == 8'(`TMR_ADDR_B_BASE + 2 * j + 1);
                case (mode_b_q[j][3:2])
                    `TMR_B_EDGE_FALL: evt = ~evt_s2_q[j] & evt_old_q[j];
                    `TMR_B_EDGE_RISE: evt = evt_s2_q[j] & ~evt_old_q[j];
                    `TMR_B_EDGE_BOTH: evt = evt_s2_q[j] ^ evt_old_q[j];
                    default:          evt = 1'b0;
                endcase
                if (j == `TMR_B_MAIN_OSCILLATOR_DIV32_CLOCK_INDEX && main_oscillator_div32_clock_q) begin
                    evt = main_oscillator_div32_clock;
                end
                case (mode_b_q[j][1:0])
                    `TMR_B_INTERVAL_CODE: count = pick_tick(div_q, mode_b_q[j][7:6], ticks);
                    `TMR_B_EVENT_CODE:    count = evt;
                    default:              count = 1'b0;
                endcase
                if (cs_q[`TMR_NUM_A + j] && count) begin
                    if (b_q[j].cnt == 16'h0000) begin
                        b_d[j].cnt = b_q[j].rel;
                        set_vec[`TMR_NUM_A + j] = 1'b1;
                    end else begin
                        b_d[j].cnt = b_q[j].cnt - 16'h0001;
                    end
                end
                if (wr_hit) begin
                    b_d[j].rel = wdata;
                    if (!cs_q[`TMR_NUM_A + j]) begin
                        b_d[j].cnt = wdata;
                    end
                end
            end

            always_ff @(posedge clock) begin
                if (!rst_b) begin
                    b_q[j] <= '0;
                end else begin
                    b_q[j] <= b_d[j];
                end
            end
        end
    endgenerate

endmodule

// >>> shared/timer_consts.svh
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define TMR_NUM_A            2
`define TMR_NUM_B            3
`define TMR_NUM_ALL          5
`define TMR_B_MAIN_OSCILLATOR_DIV32_CLOCK_INDEX     2

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TMR_ADDR_COUNT_START 8'h00
`define TMR_ADDR_ONESHOT_TRG 8'h01
`define TMR_ADDR_CLK_DIV     8'h02
`define TMR_ADDR_IRQ_FLAGS   8'h03
`define TMR_ADDR_MAIN_OSCILLATOR_DIV32_CLOCK_SEL    8'h04
`define TMR_ADDR_A_BASE      8'h10
`define TMR_ADDR_B_BASE      8'h20

// ----------------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------------
`define TMR_A_ONESHOT_CODE   3'h6
`define TMR_A_PWM_CODE       3'h7
`define TMR_A_EDGE_BIT       3
`define TMR_A_EXT_BIT        4
`define TMR_A_PWM8_BIT       5
`define TMR_B_INTERVAL_CODE  2'h0
`define TMR_B_EVENT_CODE     2'h1
`define TMR_B_EDGE_FALL      2'h0
`define TMR_B_EDGE_RISE      2'h1
`define TMR_B_EDGE_BOTH      2'h2

// ----------------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------------
`define TMR_MODE_RESET       8'h00
`define TMR_DIV_RESET        2'h0
`define TMR_DIV_FORBIDDEN    2'h3
`define TMR_PWM16_LAST       16'hfffe
`define TMR_PWM8_LAST        16'h00fe
`define TMR_MAIN_OSCILLATOR_DIV32_CLOCK_MASK        12'h01f

`endif

// >>> shared/timer_pkg.sv
package timer_pkg;

    typedef enum logic [1:0] {
        A_IDLE,
        A_ONESHOT,
        A_PWM
    } a_kind_t;

    typedef struct packed {
        logic        run;
        logic        out;
        logic [15:0] cnt;
        logic [15:0] rel;
        logic [15:0] per;
        logic [7:0]  pre;
    } timer_a_state_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] rel;
    } timer_b_state_t;

endpackage

// >>> testbench/pin_model.sv
`timescale 1ns/1ps
module pin_model (
    input  wire logic       clock,
    output logic      [1:0] trig,
    output logic      [2:0] evt
);
    initial begin
        trig = 2'h0;
        evt  = 3'h0;
    end
    // Each level stands at least four clock cycles, so retriggers keep their spacing.
    task automatic toggle(input int grp, input int idx);
        @(posedge clock);
        if (grp == 0) trig[idx] <= ~trig[idx];
        else evt[idx] <= ~evt[idx];
        repeat (3) @(posedge clock);
    endtask
endmodule

// >>> testbench/multimode_timer_chk.sv
`timescale 1ns/1ps
`include "timer_consts.svh"
module multimode_timer_chk (
    input wire logic                    clock,
    input wire logic                    rst_b,
    input wire logic [7:0]              addr,
    input wire logic [15:0]             wdata,
    input wire logic                    wr_en,
    input wire logic                    rd_en,
    input wire logic [15:0]             rdata,
    input wire logic [`TMR_NUM_A-1:0]   group_a_trigger_input_pin,
    input wire logic [`TMR_NUM_A-1:0]   group_a_pulse_output_pin,
    input wire logic [`TMR_NUM_B-1:0]   group_b_event_input_pin,
    input wire logic [`TMR_NUM_ALL-1:0] irq_request
);
    logic [4:0]  cs_q;
    logic [1:0]  div_q;
    logic [7:0]  mode_q;
    logic [15:0] rel_q;
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cs_q   <= 5'h00;
            div_q  <= 2'h0;
            mode_q <= 8'h00;
            rel_q  <= 16'h0000;
        end else if (wr_en) begin
            if (addr == `TMR_ADDR_COUNT_START) cs_q <= wdata[4:0];
            if (addr == `TMR_ADDR_CLK_DIV) div_q <= wdata[1:0];
            if (addr == `TMR_ADDR_A_BASE) mode_q <= wdata[7:0];
            if (addr == `TMR_ADDR_A_BASE + 8'h01) rel_q <= wdata;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_flag_sticky: assert property (
        !$past(wr_en && addr == `TMR_ADDR_IRQ_FLAGS) |-> (irq_request & $past(irq_request)) == $past(irq_request))
        else $error("flag dropped without a clear");
    a_fall_flag_a0: assert property (
        $fell(group_a_pulse_output_pin[0]) && !$past(wr_en) && !$past(wr_en, 2) |-> irq_request[0])
        else $error("timer a0 fall without flag");
    a_fall_flag_a1: assert property (
        $fell(group_a_pulse_output_pin[1]) && !$past(wr_en) && !$past(wr_en, 2) |-> irq_request[1])
        else $error("timer a1 fall without flag");
    a_stopped_low: assert property (
        !cs_q[0] && !$past(cs_q[0]) |-> !group_a_pulse_output_pin[0])
        else $error("pulse high while stopped");
    a_soft_trigger: assert property (
        wr_en && addr == `TMR_ADDR_ONESHOT_TRG && wdata[0] && cs_q[0] && mode_q[5:0] == 6'h06
        && rel_q != 16'h0000 && !group_a_pulse_output_pin[0] && div_q != `TMR_DIV_FORBIDDEN
        |=> group_a_pulse_output_pin[0])
        else $error("software trigger gave no pulse");
    a_pulse_width: assert property (
        $rose(group_a_pulse_output_pin[0]) && mode_q == 8'h06 && div_q == 2'h1 && rel_q == 16'h0003
        |-> group_a_pulse_output_pin[0] [*3] ##1 !group_a_pulse_output_pin[0])
        else $error("one-shot width wrong");
    a_read_reload: assert property (
        $past(rd_en && addr == `TMR_ADDR_A_BASE + 8'h01) |-> rdata == $past(rel_q))
        else $error("timer a0 read not reload value");
    a_trigger_reads_zero: assert property (
        $past(rd_en && addr == `TMR_ADDR_ONESHOT_TRG) |-> rdata == 16'h0000)
        else $error("trigger register read not zero");
endmodule
bind multimode_timer multimode_timer_chk chk_u (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .group_a_trigger_input_pin(group_a_trigger_input_pin),
    .group_a_pulse_output_pin(group_a_pulse_output_pin), .group_b_event_input_pin(group_b_event_input_pin),
    .irq_request(irq_request));

// >>> testbench/multimode_timer_tb_top.sv
`timescale 1ns/1ps
`include "timer_consts.svh"
module multimode_timer_tb_top;
    localparam logic [7:0] trg = `TMR_ADDR_ONESHOT_TRG;
    localparam logic [7:0] a0d = `TMR_ADDR_A_BASE + 8'h01;
    localparam logic [7:0] a1m = `TMR_ADDR_A_BASE + 8'h02;
    localparam logic [7:0] a1d = `TMR_ADDR_A_BASE + 8'h03;
    localparam logic [7:0] b0d = `TMR_ADDR_B_BASE + 8'h01;
    logic        clock;
    logic        rst_b;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr_en;
    logic        rd_en;
    logic [15:0] rdata;
    logic [1:0]  trig;
    logic [1:0]  pulse;
    logic [2:0]  evt;
    logic [4:0]  irq;
    logic [15:0] got;
    int          fail_count;
    int          cmp_count;
    int          n;
    multimode_timer dut_u (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .group_a_trigger_input_pin(trig), .group_a_pulse_output_pin(pulse),
        .group_b_event_input_pin(evt), .irq_request(irq));
    pin_model pins_u (.clock(clock), .trig(trig), .evt(evt));
    task automatic end_of_test();
        if (fail_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task automatic wcs(input logic [4:0] v);
        wr(`TMR_ADDR_COUNT_START, {11'h000, v});
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic wait_bit(input int sel, input int i, input logic lvl, input int bound);
        #1 n = 0;
        while ((sel == 1 ? irq[i] : pulse[i]) !== lvl && n < bound) begin
            @(posedge clock);
            #1 n++;
        end
        if (n >= bound) begin
            fail_count++;
            end_of_test();
        end
    endtask
    task automatic span(input logic lvl);
        #1 n = 0;
        while (pulse[1] === lvl && n < 70000) begin
            @(posedge clock);
            #1 n++;
        end
        if (n >= 70000) begin
            fail_count++;
            end_of_test();
        end
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        repeat (90000) @(posedge clock);
        fail_count++;
        end_of_test();
    end
    initial begin
        rst_b = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        fail_count = 0;
        cmp_count = 0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        rd(`TMR_ADDR_A_BASE);
        chk("a0 mode reset", 16'h0000, got);
        rd(8'hff);
        chk("unmapped read", 16'h0000, got);
        wr(`TMR_ADDR_CLK_DIV, 16'h0001);
        wr(`TMR_ADDR_A_BASE, 16'h0006);
        wr(a0d, 16'h0003);
        wr(a1m, 16'h0006);
        wr(a1d, 16'h0003);
        wcs(5'h03);
        wr(trg, 16'h0001);
        #1 chk("pulse start", 16'h0001, {14'h0000, pulse});
        repeat (2) @(posedge clock);
        #1 chk("pulse held", 16'h0001, {14'h0000, pulse});
        @(posedge clock);
        #1 chk("pulse end", 16'h0001, {9'h000, pulse, irq});
        wr(a0d, 16'h0005);
        rd(a0d);
        chk("a0 reload", 16'h0005, got);
        wr(trg, 16'h0001);
        wr(trg, 16'h0001);
        repeat (4) @(posedge clock);
        #1 chk("retrigger high", 16'h0001, {14'h0000, pulse});
        @(posedge clock);
        #1 chk("retrigger end", 16'h0000, {14'h0000, pulse});
        wr(trg, 16'h0001);
        wcs(5'h00);
        @(posedge clock);
        #1 chk("stopped low", 16'h0000, {14'h0000, pulse});
        wr(trg, 16'h0001);
        #1 chk("trigger refused", 16'h0000, {14'h0000, pulse});
        wcs(5'h01);
        wr(a0d, 16'h0005);
        for (int k = 0; k < 2; k++) begin
            wr(`TMR_ADDR_A_BASE, k == 0 ? 16'h001e : 16'h0016);
            pins_u.toggle(0, 0);
            wait_bit(0, 0, 1'b1, 20);
            wait_bit(0, 0, 1'b0, 20);
        end
        wr(`TMR_ADDR_IRQ_FLAGS, 16'h001f);
        #1 chk("flags cleared", 16'h0000, {11'h000, irq});
        wr(a1m, 16'h0007);
        wr(a1d, 16'h0004);
        wcs(5'h03);
        wait_bit(0, 1, 1'b1, 20);
        span(1'b1);
        chk("pwm16 high", 16'h0004, n[15:0]);
        wr(trg, 16'h0002);
        span(1'b0);
        chk("pwm16 low", 16'hfff9, n[15:0]);
        chk("pwm16 flag", 16'h0002, {11'h000, irq});
        wcs(5'h01);
        wr(a1m, 16'h0027);
        wr(a1d, 16'h0201);
        wcs(5'h03);
        wait_bit(0, 1, 1'b1, 600);
        wait_bit(0, 1, 1'b0, 600);
        wait_bit(0, 1, 1'b1, 600);
        span(1'b1);
        chk("pwm8 high", 16'h0004, n[15:0]);
        wr(a1d, 16'h0301);
        span(1'b0);
        chk("pwm8 low", 16'h01f8, n[15:0]);
        span(1'b1);
        chk("pwm8 new high", 16'h0006, n[15:0]);
        wcs(5'h01);
        wr(b0d, 16'h0040);
        rd(b0d);
        chk("b0 halted load", 16'h0040, got);
        wcs(5'h05);
        wr(b0d, 16'h1000);
        rd(b0d);
        chk("b0 running", 16'h0001, {15'h0000, got > 16'h0030 && got < 16'h0040});
        wait_bit(1, 2, 1'b1, 100);
        for (int k = 0; k < 3; k++) begin
            wcs(5'h05);
            wr(`TMR_ADDR_B_BASE + 8'h02, {12'h000, k[1:0], 2'h1});
            wr(`TMR_ADDR_B_BASE + 8'h03, 16'h0010);
            wcs(5'h0d);
            pins_u.toggle(1, 1);
            pins_u.toggle(1, 1);
            rd(`TMR_ADDR_B_BASE + 8'h03);
            chk("b1 events", k == 2 ? 16'h000e : 16'h000f, got);
        end
        wr(`TMR_ADDR_MAIN_OSCILLATOR_DIV32_CLOCK_SEL, 16'h0001);
        wr(`TMR_ADDR_B_BASE + 8'h04, 16'h0001);
        wr(`TMR_ADDR_B_BASE + 8'h05, 16'h0010);
        wr(a1m, 16'h001f);
        wr(a1d, 16'h0004);
        wcs(5'h1f);
        repeat (64) @(posedge clock);
        #1 chk("pwm ext idle", 16'h0000, {14'h0000, pulse});
        rd(`TMR_ADDR_B_BASE + 8'h05);
        chk("b2 osc count", 16'h0001, {15'h0000, got == 16'h000d || got == 16'h000e});
        pins_u.toggle(0, 1);
        wait_bit(0, 1, 1'b1, 20);
        wr(`TMR_ADDR_A_BASE, 16'h0046);
        wr(trg, 16'h0001);
        repeat (60) @(posedge clock);
        #1 chk("a0 f16 held", 16'h0001, {15'h0000, pulse[0]});
        wait_bit(0, 0, 1'b0, 25);
        end_of_test();
    end
endmodule
